// file: src/stdma_top.sv
// Simple transmit DMA engine: burst reads, scatter/gather, transmit FIFO, unpacker
// How it works
// - On a memory error raise interrupt, halt this channel, keep pointer at the error.
// - With burst-size space free, read first-length words, then burst-size bursts.
// - Each returned word within the count is pushed, pointer incremented, word counter decremented.
// - Valid is asserted while FIFO holds data; option takes words by acknowledge.
// - At a page boundary read one word at sg pointer into pointer, bump sg.
// - Last burst still reads full size but pushes only the counted words.
// - Counter reaching zero raises the interrupt output when unmasked.
// - Unpacker starts at the alignment lane; alignment 01 skips lane 0.
// - Byte order 0 means little-endian, ascending address delivery.
// - Writing queue enable 0 clears the transmit FIFO.
// - Leftover bytes are written by software with a matching alignment.
// - A readable FIFO-empty status bit lets software poll for drain.
// - Byte size hands one byte per acknowledge.
// - Data reads run only with both enables set and error, load, expired clear.
// - Counter reaching zero sets the expired flag and disables transmit DMA.
// - Each acknowledge advances after a two-flop synchronizer, on the third edge; valid drops when FIFO empties.
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/1ps
module stdma_top (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Memory read port
  output logic             mem_req,
  output logic      [31:0] mem_addr,
  output logic      [7:0]  mem_len,
  input  wire logic [31:0] mem_rdata,
  input  wire logic        mem_rvalid,
  input  wire logic        mem_rerr,
  // Option side
  input  wire logic        tx_data_ack_n,
  output logic             tx_valid_n,
  output logic      [31:0] tx_data,
  // Interrupt
  output logic             system_interrupt_n
);

  // ***************************************************************
  // Control storage
  // ***************************************************************
  logic [31:0] option_control_reg;
  logic [31:0] transmit_pointer;
  logic [31:0] transmit_sg_pointer;
  logic [23:0] transmit_word_counter;
  logic [1:0]  interrupt_mask_reg;
  logic        tx_count_expired_flag;
  logic        tx_error_flag;
  logic        tx_pending_load_flag;
  logic        first_pending;
  stdma_pkg::stdma_state_e state;
  logic [7:0]  beats;

  logic       transmit_queue_enable;
  logic       transmit_dma_enable;
  logic       keep_fifo_filled;
  logic [1:0] size_sel;
  logic [1:0] unpack_alignment;
  logic       byte_order_select;
  logic [7:0] burst_size;
  logic [7:0] first_burst_length;

  assign transmit_queue_enable = option_control_reg[stdma_pkg::CTL_TRANSMIT_QUEUE_ENABLE];
  assign transmit_dma_enable   = option_control_reg[stdma_pkg::CTL_TDMA];
  assign keep_fifo_filled      = option_control_reg[stdma_pkg::CTL_KEEP];
  assign size_sel              = option_control_reg[stdma_pkg::CTL_SIZE +: 2];
  assign unpack_alignment      = option_control_reg[stdma_pkg::CTL_ALIGN +: 2];
  assign byte_order_select     = option_control_reg[stdma_pkg::CTL_BE];
  assign burst_size            = option_control_reg[stdma_pkg::CTL_BSZ +: 8];
  assign first_burst_length    = option_control_reg[stdma_pkg::CTL_BINIT +: 8];

  // FIFO state
  logic [31:0] fifo_mem [stdma_pkg::FIFO_DEPTH];
  logic [3:0]  wr_ptr;
  logic [3:0]  rd_ptr;
  logic [4:0]  count;
  logic [1:0]  lane;
  logic        ack_s1;
  logic        ack_s2;

  // ***************************************************************
  // Decode and engine events
  // ***************************************************************
  logic wr_ctrl;
  logic wr_stat;
  logic clr_fifo;
  logic go;
  logic issue_sg;
  logic issue_data;
  logic beat;
  logic push_dma;
  logic push_pio;
  logic push;
  logic set_exp;
  logic set_err;
  logic set_pld;
  logic sg_done;
  logic [4:0]  free_words;
  logic [7:0]  next_len;
  logic [31:0] push_data;

  assign wr_ctrl  = reg_wr && (reg_addr == stdma_pkg::OFF_CTRL);
  assign wr_stat  = reg_wr && (reg_addr == stdma_pkg::OFF_STAT);
  assign clr_fifo = wr_ctrl && !reg_wdata[stdma_pkg::CTL_TRANSMIT_QUEUE_ENABLE];
  assign free_words = 5'(stdma_pkg::FIFO_DEPTH) - count;
  assign go = transmit_dma_enable && transmit_queue_enable && !tx_error_flag
           && !tx_pending_load_flag && !tx_count_expired_flag;
  assign issue_sg = (state == stdma_pkg::S_IDLE) && tx_pending_load_flag
                 && transmit_dma_enable && transmit_queue_enable && !tx_error_flag;
  assign issue_data = (state == stdma_pkg::S_IDLE) && go && (burst_size != 8'h00)
                   && ({3'h0, free_words} >= burst_size) && (keep_fifo_filled || count == 5'h00);
  assign next_len = (first_pending && first_burst_length != 8'h00) ? first_burst_length
                                                                     : burst_size;
  assign beat     = (state == stdma_pkg::S_BURST) && mem_rvalid && !mem_rerr;
  assign push_dma = beat && (transmit_word_counter != 24'h000000);
  assign set_exp  = push_dma && (transmit_word_counter == 24'h000001);
  assign set_err  = (state != stdma_pkg::S_IDLE) && mem_rvalid && mem_rerr;
  assign set_pld  = push_dma && (transmit_pointer[stdma_pkg::PAGE_BITS-1:0] == '1);
  assign sg_done  = (state == stdma_pkg::S_SG) && mem_rvalid && !mem_rerr;
  // Software writes into the FIFO are dropped while a burst is landing
  assign push_pio = reg_wr && (reg_addr == stdma_pkg::OFF_FIFO) && (state == stdma_pkg::S_IDLE)
                 && (count != 5'(stdma_pkg::FIFO_DEPTH));
  assign push      = push_dma || push_pio;
  assign push_data = push_dma ? mem_rdata : reg_wdata;

  // ***************************************************************
  // Control register
  // ***************************************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      option_control_reg <= stdma_pkg::CTRL_RST;
    end else begin
      if (wr_ctrl) begin
        option_control_reg <= reg_wdata;
      end
      if (set_exp) begin
        option_control_reg[stdma_pkg::CTL_TDMA] <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      interrupt_mask_reg <= stdma_pkg::MASK_RST;
    end else if (reg_wr && reg_addr == stdma_pkg::OFF_MASK) begin
      interrupt_mask_reg <= reg_wdata[1:0];
    end
  end

  // ***************************************************************
  // Status flags: write one to clear, hardware set wins
  // ***************************************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_count_expired_flag <= 1'b0;
      tx_error_flag         <= 1'b0;
      tx_pending_load_flag  <= 1'b0;
    end else begin
      tx_count_expired_flag <= set_exp
        || (tx_count_expired_flag && !(wr_stat && reg_wdata[stdma_pkg::ST_EXP]));
      tx_error_flag <= set_err
        || (tx_error_flag && !(wr_stat && reg_wdata[stdma_pkg::ST_ERR]));
      tx_pending_load_flag <= set_pld
        || (tx_pending_load_flag && !sg_done && !(wr_stat && reg_wdata[stdma_pkg::ST_PLD]));
    end
  end

  // ***************************************************************
  // Pointers and word counter
  // ***************************************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      transmit_pointer      <= 32'h0000_0000;
      transmit_sg_pointer   <= 32'h0000_0000;
      transmit_word_counter <= 24'h000000;
    end else begin
      if (reg_wr && reg_addr == stdma_pkg::OFF_TP) begin
        transmit_pointer <= reg_wdata;
      end
      if (reg_wr && reg_addr == stdma_pkg::OFF_SGP) begin
        transmit_sg_pointer <= reg_wdata;
      end
      if (reg_wr && reg_addr == stdma_pkg::OFF_WC) begin
        transmit_word_counter <= reg_wdata[23:0];
      end
      if (push_dma) begin
        transmit_pointer      <= transmit_pointer + 32'h0000_0001;
        transmit_word_counter <= transmit_word_counter - 24'h000001;
      end
      if (sg_done) begin
        transmit_pointer    <= mem_rdata;
        transmit_sg_pointer <= transmit_sg_pointer + 32'h0000_0001;
      end
    end
  end

  // ***************************************************************
  // Burst sequencer
  // ***************************************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state    <= stdma_pkg::S_IDLE;
      mem_req  <= 1'b0;
      mem_addr <= 32'h0000_0000;
      mem_len  <= 8'h00;
      beats    <= 8'h00;
    end else begin
      mem_req <= 1'b0;
      case (state)
        stdma_pkg::S_IDLE: begin
          beats <= 8'h00;
          if (issue_sg) begin
            mem_req  <= 1'b1;
            mem_addr <= transmit_sg_pointer;
            mem_len  <= 8'h01;
            state    <= stdma_pkg::S_SG;
          end else if (issue_data) begin
            mem_req  <= 1'b1;
            mem_addr <= transmit_pointer;
            mem_len  <= next_len;
            state    <= stdma_pkg::S_BURST;
          end
        end
        stdma_pkg::S_BURST: begin
          if (set_err) begin
            state <= stdma_pkg::S_IDLE;
          end else if (beat) begin
            beats <= beats + 8'h01;
            if (beats + 8'h01 == mem_len) begin
              state <= stdma_pkg::S_IDLE;
            end
          end
        end
        stdma_pkg::S_SG: begin
          if (mem_rvalid) begin
            state <= stdma_pkg::S_IDLE;
          end
        end
        default: state <= stdma_pkg::S_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      first_pending <= 1'b0;
    end else if (wr_ctrl && reg_wdata[stdma_pkg::CTL_TDMA] && !transmit_dma_enable) begin
      first_pending <= 1'b1;
    end else if (issue_data && !issue_sg) begin
      first_pending <= 1'b0;
    end
  end

  // ***************************************************************
  // Transmit FIFO and unpacker
  // ***************************************************************
  logic        ack;
  logic        pop;
  logic [2:0]  step;
  logic [2:0]  lane_sum;
  logic [3:0]  next_rd;
  logic [4:0]  next_count;
  logic [1:0]  next_lane;
  logic [31:0] head;

  function automatic logic [31:0] pick(input logic [31:0] w, input logic [1:0] k,
                                       input logic [2:0] nb, input logic be);
    logic [2:0]  sh;
    logic [31:0] m;
    sh = be ? 3'(3'h4 - {1'b0, k} - nb) : {1'b0, k};
    m  = (nb == 3'h1) ? 32'h0000_00FF : (nb == 3'h2) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
    return (w >> {sh, 3'h0}) & m;
  endfunction

  assign ack = !ack_s2 && !tx_valid_n;

  always_comb begin
    step = 3'h4;
    if (size_sel == stdma_pkg::SZ_BYTE) begin
      step = 3'h1;
    end else if (size_sel == stdma_pkg::SZ_HALF) begin
      step = 3'h2;
    end
    lane_sum   = {1'b0, lane} + step;
    pop        = ack && lane_sum[2];
    next_rd    = clr_fifo ? 4'h0 : rd_ptr + {3'h0, pop};
    next_count = clr_fifo ? 5'h00 : count + {4'h0, push} - {4'h0, pop};
    next_lane  = lane;
    if (clr_fifo) begin
      next_lane = reg_wdata[stdma_pkg::CTL_ALIGN +: 2];
    end else if (ack) begin
      next_lane = pop ? 2'h0 : lane_sum[1:0];
    end
    head = fifo_mem[next_rd];
    if (push && (count - {4'h0, pop}) == 5'h00) begin
      head = push_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push && !clr_fifo) begin
      fifo_mem[wr_ptr] <= push_data;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_ptr     <= 4'h0;
      rd_ptr     <= 4'h0;
      count      <= 5'h00;
      lane       <= 2'h0;
      tx_valid_n <= 1'b1;
      tx_data    <= 32'h0000_0000;
    end else begin
      wr_ptr     <= clr_fifo ? 4'h0 : wr_ptr + {3'h0, push};
      rd_ptr     <= next_rd;
      count      <= next_count;
      lane       <= next_lane;
      tx_valid_n <= (next_count == 5'h00);
      tx_data    <= pick(head, next_lane, step, byte_order_select);
    end
  end

  // Acknowledge pin arrives from the option's domain
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ack_s1 <= 1'b1;
      ack_s2 <= 1'b1;
    end else begin
      ack_s1 <= tx_data_ack_n;
      ack_s2 <= ack_s1;
    end
  end

  // ***************************************************************
  // Interrupt and read-back
  // ***************************************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      system_interrupt_n <= 1'b1;
    end else begin
      system_interrupt_n <= !(|({tx_error_flag, tx_count_expired_flag}
                                 & interrupt_mask_reg));
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= 32'h0000_0000;
      if (reg_rd) begin
        case (reg_addr)
          stdma_pkg::OFF_CTRL: reg_rdata <= option_control_reg;
          stdma_pkg::OFF_TP:   reg_rdata <= transmit_pointer;
          stdma_pkg::OFF_SGP:  reg_rdata <= transmit_sg_pointer;
          stdma_pkg::OFF_WC:   reg_rdata <= {8'h00, transmit_word_counter};
          stdma_pkg::OFF_MASK: reg_rdata <= {30'h0, interrupt_mask_reg};
          stdma_pkg::OFF_STAT: reg_rdata <= {28'h0, (count == 5'h00),
                                 tx_pending_load_flag, tx_error_flag, tx_count_expired_flag};
          default:             reg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ***************************************************************
  // Checks
  // ***************************************************************
  a_err_halts: assert property (@(posedge ref_clk) disable iff (rst)
    set_err |=> tx_error_flag && state == stdma_pkg::S_IDLE ##1 !mem_req)
    else $error("error did not halt the channel");
  a_err_ptr_hold: assert property (@(posedge ref_clk) disable iff (rst)
    (mem_rvalid && mem_rerr && !reg_wr) |=> transmit_pointer == $past(transmit_pointer))
    else $error("pointer moved on error");
  a_push_update: assert property (@(posedge ref_clk) disable iff (rst)
    (push_dma && !reg_wr) |=> transmit_word_counter == $past(transmit_word_counter) - 24'h1
      && count != 5'h00)
    else $error("word push did not update counter");
  a_sg_load: assert property (@(posedge ref_clk) disable iff (rst)
    (sg_done && !reg_wr) |=> transmit_pointer == $past(mem_rdata) && !tx_pending_load_flag)
    else $error("sg entry not loaded");
  a_expire_stop: assert property (@(posedge ref_clk) disable iff (rst)
    set_exp |=> tx_count_expired_flag && !transmit_dma_enable ##1 !issue_data)
    else $error("expiry did not stop transmit");
  a_irq_done: assert property (@(posedge ref_clk) disable iff (rst)
    (set_exp && interrupt_mask_reg[0] && !reg_wr) |-> ##2 !system_interrupt_n)
    else $error("completion interrupt missing");
  a_valid_empty: assert property (@(posedge ref_clk) disable iff (rst)
    tx_valid_n == (count == 5'h00))
    else $error("valid disagrees with fill level");
  a_clear_fifo: assert property (@(posedge ref_clk) disable iff (rst)
    clr_fifo |=> count == 5'h00 && tx_valid_n
      && lane == $past(reg_wdata[stdma_pkg::CTL_ALIGN +: 2]))
    else $error("queue disable did not clear");
  a_byte_step: assert property (@(posedge ref_clk) disable iff (rst)
    (ack && size_sel == stdma_pkg::SZ_BYTE && lane != 2'h3 && !clr_fifo)
      |=> lane == $past(lane) + 2'h1)
    else $error("byte unpack did not advance one lane");

endmodule

// file: src/stdma_pkg.sv
// Constants, register map and types for the simple transmit DMA engine
package stdma_pkg;

  // ***************************************************************
  // Structure
  // ***************************************************************
  localparam int FIFO_DEPTH = 16;
  localparam int PTR_W      = 4;
  localparam int PAGE_BITS  = 10;

  // ***************************************************************
  // Register offsets
  // ***************************************************************
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_TP   = 4'h1;
  localparam logic [3:0] OFF_SGP  = 4'h2;
  localparam logic [3:0] OFF_WC   = 4'h3;
  localparam logic [3:0] OFF_MASK = 4'h4;
  localparam logic [3:0] OFF_STAT = 4'h5;
  localparam logic [3:0] OFF_FIFO = 4'h6;

  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int CTL_TRANSMIT_QUEUE_ENABLE  = 0;
  localparam int CTL_TDMA  = 1;
  localparam int CTL_KEEP  = 2;
  localparam int CTL_SIZE  = 3;
  localparam int CTL_ALIGN = 5;
  localparam int CTL_BE    = 7;
  localparam int CTL_BSZ   = 8;
  localparam int CTL_BINIT = 16;
  localparam int ST_EXP    = 0;
  localparam int ST_ERR    = 1;
  localparam int ST_PLD    = 2;
  localparam int ST_EMPTY  = 3;

  // ***************************************************************
  // Reset values and encodings
  // ***************************************************************
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [1:0]  MASK_RST = 2'h0;
  localparam logic [1:0]  SZ_BYTE  = 2'h0;
  localparam logic [1:0]  SZ_HALF  = 2'h1;

  typedef enum logic [1:0] {S_IDLE, S_BURST, S_SG} stdma_state_e;

endpackage

// file: bench/stdma_mem_model.sv
// Memory partner: answers burst reads with address-derived words
`timescale 1ns/1ps
module stdma_mem_model (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Read request from the engine
  input  wire logic        mem_req,
  input  wire logic [31:0] mem_addr,
  input  wire logic [7:0]  mem_len,
  // Returned beats
  output logic      [31:0] mem_rdata,
  output logic             mem_rvalid,
  output logic             mem_rerr,
  // Scenario knobs
  input  wire logic [3:0]  lat,
  input  wire logic        err_on,
  input  wire logic [31:0] err_addr
);
  logic [31:0] log_addr[$];
  logic [7:0]  log_len[$];
  logic [31:0] cur;
  int          left;
  int          hold;
  // Table words with address bit 15 set (such as 0x8000) hold the next page base
  function automatic logic [31:0] word_at(input logic [31:0] a);
    if (a[15]) begin
      return 32'h0000_2000;
    end
    return {a[5:0], 2'h3, a[5:0], 2'h2, a[5:0], 2'h1, a[5:0], 2'h0};
  endfunction
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mem_rvalid <= 1'b0;
      mem_rerr   <= 1'b0;
      mem_rdata  <= 32'h0000_0000;
      left = 0;
      hold = 0;
      cur  = 32'h0000_0000;
    end else begin
      mem_rvalid <= 1'b0;
      mem_rerr   <= 1'b0;
      if (left != 0 && hold == 0) begin
        mem_rvalid <= 1'b1;
        mem_rdata  <= word_at(cur);
        if (err_on && cur == err_addr) begin
          mem_rerr <= 1'b1;
          // Rest of a failed burst is withheld
          left = 0;
        end else begin
          left = left - 1;
          cur  = cur + 32'h1;
        end
      end else begin
        // Idle data lines toggle so stale words never look valid
        mem_rdata <= ~mem_rdata;
        if (left != 0) begin
          hold = hold - 1;
        end
      end
      if (mem_req) begin
        log_addr.push_back(mem_addr);
        log_len.push_back(mem_len);
        cur  = mem_addr;
        left = int'(mem_len);
        hold = int'(lat);
      end
    end
  end
endmodule

// file: bench/test_stdma.sv
// Self-checking bench for the transmit DMA engine
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_mismatch++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module test_stdma;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic        mem_req;
  logic [31:0] mem_addr;
  logic [7:0]  mem_len;
  logic [31:0] mem_rdata;
  logic        mem_rvalid;
  logic        mem_rerr;
  logic        tx_data_ack_n = 1'b1;
  logic        tx_valid_n;
  logic [31:0] tx_data;
  logic        system_interrupt_n;
  logic [3:0]  lat = 4'h0;
  logic        err_on = 1'b0;
  logic [31:0] err_addr = 32'h0;
  int          n_mismatch = 0;
  int          check_count = 0;
  int          k;
  logic [31:0] a;
  stdma_top u_dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_len(mem_len), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid),
    .mem_rerr(mem_rerr), .tx_data_ack_n(tx_data_ack_n), .tx_valid_n(tx_valid_n),
    .tx_data(tx_data), .system_interrupt_n(system_interrupt_n));
  stdma_mem_model u_mem (.ref_clk(ref_clk), .rst(rst), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_len(mem_len), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid), .mem_rerr(mem_rerr),
    .lat(lat), .err_on(err_on), .err_addr(err_addr));
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] wexp(input logic [31:0] x);
    return {x[5:0], 2'h3, x[5:0], 2'h2, x[5:0], 2'h1, x[5:0], 2'h0};
  endfunction
  task automatic wr(input logic [3:0] ad, input logic [31:0] d);
    reg_addr  <= ad;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rchk(input logic [3:0] ad, input logic [31:0] e);
    reg_addr <= ad;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
    @(posedge ref_clk);
  endtask
  // Option side: check the head word, then one acknowledge pulse
  task automatic take(input logic [31:0] e, input logic [31:0] m);
    int i;
    for (i = 0; i < 300 && tx_valid_n !== 1'b0; i++) @(posedge ref_clk);
    #1;
    `CHK(tx_valid_n, 1'b0)
    `CHK(tx_data & m, e)
    @(posedge ref_clk);
    tx_data_ack_n <= 1'b0;
    @(posedge ref_clk);
    tx_data_ack_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic logchk(input int i, input logic [31:0] ad, input logic [7:0] n);
    `CHK(u_mem.log_addr[i], ad)
    `CHK(u_mem.log_len[i], n)
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (6000) @(posedge ref_clk);
    n_mismatch++;
    $display("watchdog expired");
    conclude();
  end
  // ********************
  // Tests
  // ********************
  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    `CHK(tx_valid_n, 1'b1)
    `CHK(system_interrupt_n, 1'b1)
    rchk(stdma_pkg::OFF_CTRL, stdma_pkg::CTRL_RST);
    rchk(stdma_pkg::OFF_STAT, 32'h8);
    rchk(4'hF, 32'h0);
    $display("test reset done");
    wr(stdma_pkg::OFF_TP, 32'h10);
    wr(stdma_pkg::OFF_WC, 32'h6);
    wr(stdma_pkg::OFF_MASK, 32'h1);
    wr(stdma_pkg::OFF_CTRL, 32'h417);
    for (k = 0; k < 6; k++) take(wexp(32'h10 + k), 32'hFFFF_FFFF);
    `CHK(tx_valid_n, 1'b1)
    logchk(0, 32'h10, 8'h4);
    logchk(1, 32'h14, 8'h4);
    `CHK(u_mem.log_addr.size(), 2)
    rchk(stdma_pkg::OFF_TP, 32'h16);
    rchk(stdma_pkg::OFF_WC, 32'h0);
    rchk(stdma_pkg::OFF_STAT, 32'h9);
    rchk(stdma_pkg::OFF_CTRL, 32'h415);
    `CHK(system_interrupt_n, 1'b0)
    wr(stdma_pkg::OFF_STAT, 32'h7);
    repeat (3) @(posedge ref_clk);
    `CHK(system_interrupt_n, 1'b1)
    $display("test word done");
    wr(stdma_pkg::OFF_CTRL, 32'h20);
    wr(stdma_pkg::OFF_TP, 32'h20);
    wr(stdma_pkg::OFF_WC, 32'h2);
    wr(stdma_pkg::OFF_CTRL, 32'h427);
    for (k = 1; k < 8; k++) begin
      a = 32'h20 + k / 4;
      take({24'h0, a[5:0], k[1:0]}, 32'hFF);
    end
    logchk(2, 32'h20, 8'h4);
    wr(stdma_pkg::OFF_STAT, 32'h7);
    $display("test byte done");
    lat <= 4'h3;
    wr(stdma_pkg::OFF_SGP, 32'h8000);
    wr(stdma_pkg::OFF_TP, 32'h3FE);
    wr(stdma_pkg::OFF_WC, 32'h4);
    wr(stdma_pkg::OFF_CTRL, 32'h0002_0417);
    for (k = 0; k < 4; k++) begin
      a = (k < 2) ? 32'h3FE + k : 32'h1FFE + k;
      take(wexp(a), 32'hFFFF_FFFF);
    end
    logchk(3, 32'h3FE, 8'h2);
    logchk(4, 32'h8000, 8'h1);
    logchk(5, 32'h2000, 8'h4);
    rchk(stdma_pkg::OFF_SGP, 32'h8001);
    rchk(stdma_pkg::OFF_TP, 32'h2002);
    wr(stdma_pkg::OFF_STAT, 32'h7);
    lat <= 4'h0;
    $display("test page done");
    err_addr <= 32'h42;
    err_on   <= 1'b1;
    wr(stdma_pkg::OFF_MASK, 32'h3);
    wr(stdma_pkg::OFF_TP, 32'h40);
    wr(stdma_pkg::OFF_WC, 32'h8);
    wr(stdma_pkg::OFF_CTRL, 32'h417);
    repeat (30) @(posedge ref_clk);
    `CHK(system_interrupt_n, 1'b0)
    `CHK(tx_valid_n, 1'b0)
    `CHK(u_mem.log_addr.size(), 7)
    logchk(6, 32'h40, 8'h4);
    rchk(stdma_pkg::OFF_TP, 32'h42);
    rchk(stdma_pkg::OFF_WC, 32'h6);
    rchk(stdma_pkg::OFF_STAT, 32'h2);
    wr(stdma_pkg::OFF_CTRL, 32'h0);
    repeat (2) @(posedge ref_clk);
    `CHK(tx_valid_n, 1'b1)
    rchk(stdma_pkg::OFF_STAT, 32'hA);
    wr(stdma_pkg::OFF_STAT, 32'h7);
    err_on <= 1'b0;
    $display("test error done");
    wr(stdma_pkg::OFF_CTRL, 32'h40);
    wr(stdma_pkg::OFF_CTRL, 32'h41);
    wr(stdma_pkg::OFF_FIFO, 32'hDDCC_BBAA);
    take(32'hCC, 32'hFF);
    take(32'hDD, 32'hFF);
    `CHK(tx_valid_n, 1'b1)
    rchk(stdma_pkg::OFF_STAT, 32'h8);
    $display("test leftover done");
    wr(stdma_pkg::OFF_CTRL, 32'h08);
    wr(stdma_pkg::OFF_CTRL, 32'h09);
    wr(stdma_pkg::OFF_FIFO, 32'h4433_2211);
    take(32'h2211, 32'hFFFF_FFFF);
    take(32'h4433, 32'hFFFF_FFFF);
    wr(stdma_pkg::OFF_CTRL, 32'h88);
    wr(stdma_pkg::OFF_CTRL, 32'h89);
    wr(stdma_pkg::OFF_FIFO, 32'h4433_2211);
    take(32'h4433, 32'hFFFF_FFFF);
    take(32'h2211, 32'hFFFF_FFFF);
    `CHK(tx_valid_n, 1'b1)
    $display("test half done");
    conclude();
  end
endmodule
